// File: verilog/slsp_source_port.v
// transmit source port of a multi-lane streaming link, with reset sequencer,
// user clock generator, adaptation fifo, error vector and wishbone registers
// assumes all user inputs are synchronous to clk_sys and lane serial clocks
// plus transceiver lock are handled outside, lock arriving already combined
`timescale 1ns/10ps
`include "slsp_defs.vh"

module slsp_source_port (
	input wire clk_sys,
	input wire rst_n,
	input wire coreReset,
	input wire txPllLocked,
	input wire userClockTxIn,
	output reg userClockTxOut,
	output wire userClockTxOe,
	input wire userClockResetTxIn,
	output wire userClockResetTxOut,
	output wire userClockResetTxOe,
	output wire interfaceClockResetTx,
	output wire linkUpTx,
	input wire [`SLSP_DATA_W-1:0] dataTx,
	input wire [`SLSP_SYNC_W-1:0] syncTx,
	input wire validTx,
	input wire sourceBurstFirst,
	input wire sourceBurstLast,
	output reg [`SLSP_ERR_W-1:0] errorTx,
	output wire [`SLSP_DATA_W-1:0] laneData,
	output wire [`SLSP_SYNC_W-1:0] laneSync,
	output wire laneFirst,
	output wire laneLast,
	output wire laneValid,
	input wire laneReady,
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [3:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatI,
	output reg [31:0] wbDatO,
	output reg wbAck,
	output wire irq
);

	// ----------------------------------------------------------------
	// states and derived counts
	// ----------------------------------------------------------------
	localparam [3:0] ST_RESET = 4'h1;
	localparam [3:0] ST_WAIT_LOCK = 4'h2;
	localparam [3:0] ST_SETTLE = 4'h4;
	localparam [3:0] ST_READY = 4'h8;
	// counts are worked out wide and then cut to the counter widths
	localparam [31:0] SETTLE_LAST_W = `SLSP_SETTLE_CYC - 1;
	localparam [7:0] SETTLE_LAST = SETTLE_LAST_W[7:0];
	localparam [31:0] UCLK_LAST_W = `SLSP_UCLK_HALF - 1;
	localparam [1:0] UCLK_LAST = UCLK_LAST_W[1:0];

	reg [31:0] ctrlReg;
	reg [`SLSP_IRQ_W-1:0] irqStat;
	reg [`SLSP_IRQ_W-1:0] irqMask;
	reg [3:0] seqState;
	reg [3:0] next_seqState;
	reg [7:0] settleCnt;
	reg relMeta;
	reg relSync;
	reg [1:0] uclkCnt;
	reg [7:0] gapCnt;
	reg lastSeen;
	reg [`SLSP_SYNC_W-1:0] burstSync;
	reg linkUpPrev;
	wire linkRst_n;
	wire advMode;
	wire burstMode;
	wire eccOn;
	wire [7:0] cfgGap;
	wire seqDone;
	wire accept;
	wire fifoFlush;
	wire fifoOverflow;
	wire seuFixed;
	wire seuBad;
	wire gapError;
	wire [`SLSP_SYNC_W-1:0] entrySync;
	wire [`SLSP_FIFO_AW:0] fifoLevel;
	wire [`SLSP_IRQ_W-1:0] irqEvents;
	wire wbReq;
	wire [31:0] wrMask;

	// expand wishbone byte selects into a bit mask
	function [31:0] selMask;
		input [3:0] sel;
		begin
			selMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	// merge a masked write into an old register value
	function [31:0] mergeWr;
		input [31:0] old;
		input [31:0] dat;
		input [31:0] msk;
		begin
			mergeWr = (old & ~msk) | (dat & msk);
		end
	endfunction

	assign advMode = ctrlReg[`SLSP_CTRL_ADV];
	assign burstMode = ctrlReg[`SLSP_CTRL_BURST];
	assign eccOn = ctrlReg[`SLSP_CTRL_ECC];
	assign cfgGap = ctrlReg[`SLSP_CTRL_GAP_HI:`SLSP_CTRL_GAP_LO];

	// ----------------------------------------------------------------
	// user clock generator
	// ----------------------------------------------------------------
	// stands in for the clock synthesiser, so the master link reset
	// leaves it running and only the system reset stops it
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			uclkCnt <= 2'h0;
			userClockTxOut <= 1'b0;
		end
		else if (uclkCnt == UCLK_LAST)
		begin
			uclkCnt <= 2'h0;
			userClockTxOut <= ~userClockTxOut;
		end
		else
			uclkCnt <= uclkCnt + 2'h1;
	end

	// pin is driven only in standard mode, advanced mode takes it in
	assign userClockTxOe = ~advMode;

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	// master reset is active high and acts without the clock
	assign linkRst_n = rst_n & ~coreReset;

	// release is resynchronised so the sequencer leaves reset cleanly
	always @(posedge clk_sys or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			relMeta <= 1'b0;
			relSync <= 1'b0;
		end
		else
		begin
			relMeta <= 1'b1;
			relSync <= relMeta;
		end
	end

	// walk from reset through lock and a settle time to ready;
	// lock loss drops the link back to waiting
	always @*
	begin
		next_seqState = seqState;
		case (seqState)
			ST_RESET: if (relSync) next_seqState = ST_WAIT_LOCK;
			ST_WAIT_LOCK: if (txPllLocked) next_seqState = ST_SETTLE;
			ST_SETTLE:
			begin
				if (!txPllLocked)
					next_seqState = ST_WAIT_LOCK;
				else if (settleCnt == SETTLE_LAST)
					next_seqState = ST_READY;
			end
			ST_READY: if (!txPllLocked) next_seqState = ST_WAIT_LOCK;
			default: next_seqState = ST_RESET;
		endcase
	end

	always @(posedge clk_sys or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			seqState <= ST_RESET;
			settleCnt <= 8'h00;
		end
		else
		begin
			seqState <= next_seqState;
			if (seqState == ST_SETTLE)
				settleCnt <= settleCnt + 8'h01;
			else
				settleCnt <= 8'h00;
		end
	end

	assign seqDone = (seqState == ST_READY);
	// standard mode: user reset is an output held through the sequence
	assign userClockResetTxOut = ~advMode & ~seqDone;
	assign userClockResetTxOe = ~advMode;
	// advanced mode: interface reset mirrors the sequence instead
	assign interfaceClockResetTx = advMode & ~seqDone;
	// ready needs a finished sequence and, in advanced mode, no user reset
	assign linkUpTx = seqDone & ~(advMode & userClockResetTxIn);

	// ----------------------------------------------------------------
	// intake and adaptation fifo
	// ----------------------------------------------------------------
	// anything offered without valid or before ready is dropped silently
	assign accept = validTx & linkUpTx;
	assign fifoFlush = ~seqDone | (advMode & userClockResetTxIn);
	// start and end words carry the sync byte as offered, middle words
	// repeat the start value so the far end always sees a defined byte
	assign entrySync = (sourceBurstFirst | sourceBurstLast) ? syncTx : burstSync;

	always @(posedge clk_sys or negedge linkRst_n)
	begin
		if (!linkRst_n)
			burstSync <= 8'h00;
		else if (accept & sourceBurstFirst)
			burstSync <= syncTx;
	end

	slsp_adapt_fifo u_fifo (
		.clk_sys(clk_sys),
		.rst_n(linkRst_n),
		.flush(fifoFlush),
		.pushValid(accept),
		.pushData(dataTx),
		.pushSync(entrySync),
		.pushFirst(sourceBurstFirst),
		.pushLast(sourceBurstLast),
		.pushOverflow(fifoOverflow),
		.outData(laneData),
		.outSync(laneSync),
		.outFirst(laneFirst),
		.outLast(laneLast),
		.outValid(laneValid),
		.outReady(laneReady),
		.seuFixed(seuFixed),
		.seuBad(seuBad),
		.level(fifoLevel)
	);

	// ----------------------------------------------------------------
	// burst gap check
	// ----------------------------------------------------------------
	// counts clock cycles strictly between an accepted last and the next
	// accepted first; saturates so a long idle cannot wrap into a match
	always @(posedge clk_sys or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			gapCnt <= 8'h00;
			lastSeen <= 1'b0;
		end
		else if (accept & sourceBurstLast)
		begin
			gapCnt <= 8'h00;
			lastSeen <= 1'b1;
		end
		else
		begin
			if (accept & sourceBurstFirst)
				lastSeen <= 1'b0;
			if (gapCnt != 8'hFF)
				gapCnt <= gapCnt + 8'h01;
		end
	end

	// continuous mode has no gaps to check
	assign gapError = burstMode & accept & sourceBurstFirst & lastSeen
		& (gapCnt != cfgGap);

	// ----------------------------------------------------------------
	// error vector
	// ----------------------------------------------------------------
	// one-cycle pulses; upset bits stay low while correction is off
	always @(posedge clk_sys or negedge linkRst_n)
	begin
		if (!linkRst_n)
			errorTx <= 4'h0;
		else
		begin
			errorTx[`SLSP_ERR_OVF] <= fifoOverflow;
			errorTx[`SLSP_ERR_SEU_FIX] <= eccOn & seuFixed;
			errorTx[`SLSP_ERR_SEU_BAD] <= eccOn & seuBad;
			errorTx[`SLSP_ERR_GAP] <= gapError;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			linkUpPrev <= 1'b0;
		else
			linkUpPrev <= linkUpTx;
	end

	assign irqEvents = {linkUpTx & ~linkUpPrev, errorTx};
	assign irq = |(irqStat & irqMask);

	// ----------------------------------------------------------------
	// wishbone register slave
	// ----------------------------------------------------------------
	assign wbReq = wbCyc & wbStb & ~wbAck;
	assign wrMask = selMask(wbSel);

	// every access is acked one cycle after the strobe; unmapped reads
	// return zero and unmapped writes are dropped
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wbAck <= 1'b0;
			wbDatO <= 32'h00000000;
			ctrlReg <= `SLSP_CTRL_RST;
			irqStat <= 5'h00;
			irqMask <= 5'h00;
		end
		else
		begin
			wbAck <= wbReq;
			// a new event beats a write-one clear in the same cycle
			if (wbReq & wbWe & (wbAdr[3:2] == `SLSP_REG_IRQ_STAT))
				irqStat <= (irqStat & ~(wbDatI[`SLSP_IRQ_W-1:0]
					& wrMask[`SLSP_IRQ_W-1:0])) | irqEvents;
			else
				irqStat <= irqStat | irqEvents;
			if (wbReq & wbWe)
			begin
				case (wbAdr[3:2])
					`SLSP_REG_CTRL: ctrlReg <= mergeWr(ctrlReg, wbDatI, wrMask)
						& 32'h0000FF07;
					`SLSP_REG_IRQ_MASK: irqMask <= (irqMask & ~wrMask[`SLSP_IRQ_W-1:0])
						| (wbDatI[`SLSP_IRQ_W-1:0] & wrMask[`SLSP_IRQ_W-1:0]);
					default: ctrlReg <= ctrlReg;
				endcase
			end
			if (wbReq & ~wbWe)
			begin
				case (wbAdr[3:2])
					`SLSP_REG_CTRL: wbDatO <= ctrlReg;
					`SLSP_REG_STATUS: wbDatO <= {21'h000000, fifoLevel, 5'h00,
						seqState[0], txPllLocked, linkUpTx};
					`SLSP_REG_IRQ_STAT: wbDatO <= {27'h0000000, irqStat};
					`SLSP_REG_IRQ_MASK: wbDatO <= {27'h0000000, irqMask};
					default: wbDatO <= 32'h00000000;
				endcase
			end
		end
	end

	// userClockTxIn is the external user clock in advanced mode; this port
	// runs entirely on clk_sys, so the pin is only observed, never used as a clock
	wire unusedUclk;
	assign unusedUclk = userClockTxIn;

endmodule // slsp_source_port

// File: verilog/slsp_defs.vh
// constants shared by the streaming link source port and its adaptation fifo
// assumes one 40 MHz system clock and a fixed lane count
`ifndef SLSP_DEFS_VH
`define SLSP_DEFS_VH

// ----------------------------------------------------------------
// stream widths
// ----------------------------------------------------------------
`define SLSP_LANES 2
`define SLSP_DATA_W 128
`define SLSP_SYNC_W 8
`define SLSP_ERR_W 4
`define SLSP_ERR_OVF 0
`define SLSP_ERR_SEU_FIX 1
`define SLSP_ERR_SEU_BAD 2
`define SLSP_ERR_GAP 3

// ----------------------------------------------------------------
// adaptation fifo geometry and entry layout
// ----------------------------------------------------------------
`define SLSP_FIFO_DEPTH 3'h4
`define SLSP_FIFO_AW 2
`define SLSP_PTR_ONE 2'h1
`define SLSP_CNT_ONE 3'h1
`define SLSP_ENTRY_W (`SLSP_DATA_W + `SLSP_SYNC_W + 7)
`define SLSP_E_SYNC_LO `SLSP_DATA_W
`define SLSP_E_LAST_LO (`SLSP_DATA_W + `SLSP_SYNC_W)
`define SLSP_E_FIRST_LO (`SLSP_DATA_W + `SLSP_SYNC_W + 3)
`define SLSP_E_PAR (`SLSP_DATA_W + `SLSP_SYNC_W + 6)

// ----------------------------------------------------------------
// register map (word index = wbAdr[3:2])
// ----------------------------------------------------------------
`define SLSP_REG_CTRL 2'h0
`define SLSP_REG_STATUS 2'h1
`define SLSP_REG_IRQ_STAT 2'h2
`define SLSP_REG_IRQ_MASK 2'h3
`define SLSP_CTRL_ADV 0
`define SLSP_CTRL_BURST 1
`define SLSP_CTRL_ECC 2
`define SLSP_CTRL_GAP_LO 8
`define SLSP_CTRL_GAP_HI 15
`define SLSP_CTRL_RST 32'h00000002
`define SLSP_IRQ_W 5
`define SLSP_IRQ_LINKUP 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLSP_CLK_PERIOD_NS 25
`define SLSP_RESET_SEQ_NS 500
`define SLSP_SETTLE_CYC ((`SLSP_RESET_SEQ_NS + `SLSP_CLK_PERIOD_NS - 1) / `SLSP_CLK_PERIOD_NS)
`define SLSP_UCLK_HALF 2

`endif

// File: verilog/slsp_adapt_fifo.v
// source adaptation fifo: flop storage, parity on payload, triplicated markers
// assumes the caller only pushes accepted words and drains with outReady
`timescale 1ns/10ps
`include "slsp_defs.vh"

module slsp_adapt_fifo (
	input wire clk_sys,
	input wire rst_n,
	input wire flush,
	input wire pushValid,
	input wire [`SLSP_DATA_W-1:0] pushData,
	input wire [`SLSP_SYNC_W-1:0] pushSync,
	input wire pushFirst,
	input wire pushLast,
	output wire pushOverflow,
	output reg [`SLSP_DATA_W-1:0] outData,
	output reg [`SLSP_SYNC_W-1:0] outSync,
	output reg outFirst,
	output reg outLast,
	output reg outValid,
	input wire outReady,
	output reg seuFixed,
	output reg seuBad,
	output wire [`SLSP_FIFO_AW:0] level
);

	// ----------------------------------------------------------------
	// storage and pointers
	// ----------------------------------------------------------------
	reg [`SLSP_ENTRY_W-1:0] mem [0:3];
	reg [`SLSP_FIFO_AW-1:0] wrPtr;
	reg [`SLSP_FIFO_AW-1:0] rdPtr;
	reg [`SLSP_FIFO_AW:0] count;
	wire [`SLSP_ENTRY_W-1:0] head;
	wire doPop;
	wire doPush;
	wire [`SLSP_ENTRY_W-1:0] newEntry;

	// majority vote of a triplicated marker
	function maj3;
		input [2:0] v;
		begin
			maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
		end
	endfunction

	assign head = mem[rdPtr];
	assign doPop = (count != 3'h0) & (~outValid | outReady);
	// a full fifo still takes a word when the head leaves in the same cycle
	assign doPush = pushValid & ((count != `SLSP_FIFO_DEPTH) | doPop);
	assign pushOverflow = pushValid & ~doPush;
	assign level = count;
	assign newEntry = {^pushData, {3{pushFirst}}, {3{pushLast}}, pushSync, pushData};

	// write side, storage has no reset since count guards every read
	always @(posedge clk_sys)
	begin
		if (doPush & ~flush)
			mem[wrPtr] <= newEntry;
	end

	// pointers, occupancy and output stage
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr <= 2'h0;
			rdPtr <= 2'h0;
			count <= 3'h0;
			outValid <= 1'b0;
			outData <= {`SLSP_DATA_W{1'b0}};
			outSync <= 8'h00;
			outFirst <= 1'b0;
			outLast <= 1'b0;
			seuFixed <= 1'b0;
			seuBad <= 1'b0;
		end
		else if (flush)
		begin
			wrPtr <= 2'h0;
			rdPtr <= 2'h0;
			count <= 3'h0;
			outValid <= 1'b0;
			seuFixed <= 1'b0;
			seuBad <= 1'b0;
		end
		else
		begin
			if (doPush)
				wrPtr <= wrPtr + `SLSP_PTR_ONE;
			if (doPop)
				rdPtr <= rdPtr + `SLSP_PTR_ONE;
			if (doPush & ~doPop)
				count <= count + `SLSP_CNT_ONE;
			else if (doPop & ~doPush)
				count <= count - `SLSP_CNT_ONE;
			seuFixed <= 1'b0;
			seuBad <= 1'b0;
			if (doPop)
			begin
				outValid <= 1'b1;
				outData <= head[`SLSP_DATA_W-1:0];
				outSync <= head[`SLSP_E_LAST_LO-1:`SLSP_E_SYNC_LO];
				outFirst <= maj3(head[`SLSP_E_FIRST_LO+2:`SLSP_E_FIRST_LO]);
				outLast <= maj3(head[`SLSP_E_LAST_LO+2:`SLSP_E_LAST_LO]);
				// a split vote is repaired by the majority, a parity slip is not
				seuFixed <= ~(&head[`SLSP_E_FIRST_LO+2:`SLSP_E_FIRST_LO]
					| ~|head[`SLSP_E_FIRST_LO+2:`SLSP_E_FIRST_LO])
					| ~(&head[`SLSP_E_LAST_LO+2:`SLSP_E_LAST_LO]
					| ~|head[`SLSP_E_LAST_LO+2:`SLSP_E_LAST_LO]);
				seuBad <= head[`SLSP_E_PAR] ^ (^head[`SLSP_DATA_W-1:0]);
			end
			else if (outReady)
				outValid <= 1'b0;
		end
	end

endmodule // slsp_adapt_fifo

// File: bench/slsp_props.sv
// checker for the streaming link source port, bound from the bench top
// assumes the single clk_sys domain and rst_n as its reset
`timescale 1ns/10ps
`include "slsp_defs.vh"
module slsp_props (
	input wire clk_sys,
	input wire rst_n,
	input wire coreReset,
	input wire txPllLocked,
	input wire userClockTxOut,
	input wire userClockTxOe,
	input wire userClockResetTxOut,
	input wire userClockResetTxOe,
	input wire interfaceClockResetTx,
	input wire linkUpTx,
	input wire validTx,
	input wire sourceBurstFirst,
	input wire [`SLSP_ERR_W-1:0] errorTx,
	input wire [`SLSP_DATA_W-1:0] laneData,
	input wire laneValid,
	input wire laneReady,
	input wire wbCyc,
	input wire wbStb,
	input wire wbAck
);
	// cycles since any reset ended; link up may not beat the settle time
	reg [7:0] quietCnt;
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			quietCnt <= 8'h00;
		else if (coreReset)
			quietCnt <= 8'h00;
		else if (quietCnt != 8'hFF)
			quietCnt <= quietCnt + 8'h01;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("bus request not acknowledged in the next cycle");
	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("acknowledge longer than one cycle");
	a_link_settle: assert property ($rose(linkUpTx) |-> quietCnt >= 8'h14 && txPllLocked)
		else $error("link up before settle time or without lock");
	a_link_core_rst: assert property (coreReset |=> !linkUpTx && !laneValid)
		else $error("core reset left link or lane active");
	a_user_rst_hold: assert property (coreReset && userClockResetTxOe |=> userClockResetTxOut)
		else $error("user reset low during core reset");
	a_if_rst_adv: assert property (coreReset && !userClockTxOe |=> interfaceClockResetTx)
		else $error("interface reset low during core reset");
	a_if_rst_std: assert property (userClockTxOe |-> !interfaceClockResetTx)
		else $error("interface reset raised in standard mode");
	a_mode_pins: assert property (userClockTxOe == userClockResetTxOe)
		else $error("clock and reset pin directions disagree");
	// the user clock keeps running through core reset, yet quietCnt restarts on core reset, so the gate waits out start-up and every core reset
	a_uclk_toggle: assert property (quietCnt >= 8'h04 |-> userClockTxOut != $past(userClockTxOut, 2))
		else $error("user clock not toggling every two cycles");
	a_ovf_cause: assert property (errorTx[`SLSP_ERR_OVF] |-> $past(validTx && linkUpTx))
		else $error("overflow flagged without an offered word");
	a_gap_cause: assert property (errorTx[`SLSP_ERR_GAP] |-> $past(validTx && linkUpTx && sourceBurstFirst))
		else $error("gap error without an accepted burst start");
	a_lane_hold: assert property (laneValid && !laneReady |=> laneValid && $stable(laneData))
		else $error("lane word changed while stalled");
	c_link_up: cover property ($rose(linkUpTx));
	c_overflow: cover property (errorTx[`SLSP_ERR_OVF]);
	c_gap_err: cover property (errorTx[`SLSP_ERR_GAP]);
	c_bus_ack: cover property (wbAck);
endmodule // slsp_props

// File: bench/slsp_user_src.sv
// user streaming source model: one transmit word per call
// assumes calls are made just after a clk_sys rising edge
`timescale 1ns/10ps
`include "slsp_defs.vh"
module slsp_user_src (
	input wire clk_sys,
	output reg [`SLSP_DATA_W-1:0] dataTx,
	output reg [`SLSP_SYNC_W-1:0] syncTx,
	output reg validTx,
	output reg sourceBurstFirst,
	output reg sourceBurstLast
);
	initial
	begin
		dataTx = 128'h0;
		syncTx = 8'h00;
		validTx = 1'b0;
		sourceBurstFirst = 1'b0;
		sourceBurstLast = 1'b0;
	end
	// full 64 bits per lane with valid up on every data cycle
	task word(input [`SLSP_DATA_W-1:0] d, input [`SLSP_SYNC_W-1:0] s, input f, input l);
	begin
		dataTx <= d;
		syncTx <= s;
		validTx <= 1'b1;
		sourceBurstFirst <= f;
		sourceBurstLast <= l;
		@(posedge clk_sys);
	end
	endtask
	// idle lines are inverted so a stale word can never pass as held
	task stop();
	begin
		validTx <= 1'b0;
		sourceBurstFirst <= 1'b0;
		sourceBurstLast <= 1'b0;
		dataTx <= ~dataTx;
		syncTx <= ~syncTx;
	end
	endtask
endmodule // slsp_user_src

// File: bench/slsp_source_port_tb_top.sv
// self-checking bench for the streaming link source port
// assumes the design files under verilog/ and the include path set to it
`timescale 1ns/10ps
`include "slsp_defs.vh"
module slsp_source_port_tb_top;
	reg clk_sys, rst_n, coreReset, txPllLocked, userClockResetTxIn, laneReady;
	reg wbCyc, wbStb, wbWe;
	reg [3:0] wbAdr, wbSel;
	reg [31:0] wbDatI, rd;
	wire [31:0] wbDatO;
	wire [127:0] dataTx, laneData;
	wire [7:0] syncTx, laneSync;
	wire validTx, sourceBurstFirst, sourceBurstLast, laneFirst, laneLast, laneValid;
	wire wbAck, irq, userClockTxOe, userClockResetTxOut, interfaceClockResetTx, linkUpTx;
	wire [3:0] errorTx;
	integer errorCnt, checksDone, gapErrs;
	reg [137:0] rxQ[$];
	slsp_source_port i_slsp_source_port (.clk_sys(clk_sys), .rst_n(rst_n), .coreReset(coreReset),
		.txPllLocked(txPllLocked), .userClockTxIn(1'b0), .userClockTxOut(),
		.userClockTxOe(userClockTxOe), .userClockResetTxIn(userClockResetTxIn),
		.userClockResetTxOut(userClockResetTxOut), .userClockResetTxOe(),
		.interfaceClockResetTx(interfaceClockResetTx), .linkUpTx(linkUpTx), .dataTx(dataTx),
		.syncTx(syncTx), .validTx(validTx), .sourceBurstFirst(sourceBurstFirst),
		.sourceBurstLast(sourceBurstLast), .errorTx(errorTx), .laneData(laneData),
		.laneSync(laneSync), .laneFirst(laneFirst), .laneLast(laneLast), .laneValid(laneValid),
		.laneReady(laneReady), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .irq(irq));
	slsp_user_src i_slsp_user_src (.clk_sys(clk_sys), .dataTx(dataTx), .syncTx(syncTx),
		.validTx(validTx), .sourceBurstFirst(sourceBurstFirst), .sourceBurstLast(sourceBurstLast));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// lane sink and gap error counter sample settled pre-edge values;
	// each 64-bit lane slice stands for a lane whose serial clock lives outside
	always @(posedge clk_sys)
	begin
		if (laneValid === 1'b1 && laneReady === 1'b1)
			rxQ.push_back({laneFirst, laneLast, laneSync, laneData});
		if (errorTx[3] === 1'b1)
			gapErrs <= gapErrs + 1;
	end
	task check(input [137:0] seen, input [137:0] exp);
	begin
		checksDone = checksDone + 1;
		if (seen !== exp)
		begin
			errorCnt = errorCnt + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task finalReport;
	begin
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// one classic bus cycle; held until ack is sampled, bounded wait
	task wbXfer(input we, input [3:0] a, input [31:0] d, output [31:0] q);
		integer n;
	begin
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'hF;
		wbDatI <= d;
		n = 0;
		@(posedge clk_sys);
		while (wbAck !== 1'b1 && n < 50)
		begin
			@(posedge clk_sys);
			n = n + 1;
		end
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (n >= 50)
		begin
			errorCnt = errorCnt + 1;
			finalReport;
		end
		@(posedge clk_sys);
	end
	endtask
	task waitLink;
		integer n;
	begin
		n = 0;
		while (linkUpTx !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			n = n + 1;
		end
		check(linkUpTx, 1'b1);
		if (n >= 100)
			finalReport;
	end
	endtask
	// middle words carry 8'h77 on sync; the lane must repeat the start value
	task burst(input integer n, input [7:0] tg);
		integer i;
	begin
		for (i = 0; i < n; i = i + 1)
			i_slsp_user_src.word({8{tg, i[7:0]}}, (i == n - 1) ? 8'h01 : ((i == 0) ? 8'h5A : 8'h77),
				i == 0, i == n - 1);
	end
	endtask
	task checkRx(input integer n, input [7:0] tg);
		integer i;
		reg [137:0] q;
	begin
		i = 0;
		while (rxQ.size() < n && i < 50)
		begin
			@(posedge clk_sys);
			i = i + 1;
		end
		if (rxQ.size() < n)
		begin
			errorCnt = errorCnt + 1;
			finalReport;
		end
		for (i = 0; i < n; i = i + 1)
		begin
			q = (rxQ.size() > 0) ? rxQ.pop_front() : 138'h0;
			check(q, {i == 0, i == n - 1, (i == n - 1) ? 8'h01 : 8'h5A, {8{tg, i[7:0]}}});
		end
	end
	endtask
	initial
	begin
		#500000;
		errorCnt = errorCnt + 1;
		finalReport;
	end
	initial
	begin
		errorCnt = 0;
		checksDone = 0;
		gapErrs = 0;
		rst_n = 1'b0;
		coreReset = 1'b0;
		txPllLocked = 1'b1;
		userClockResetTxIn = 1'b0;
		laneReady = 1'b1;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 4'h0;
		wbSel = 4'h0;
		wbDatI = 32'h0;
		repeat (6) @(posedge clk_sys);
		check(userClockResetTxOut, 1'b1);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		wbXfer(1'b0, 4'h0, 32'h0, rd);
		check(rd, `SLSP_CTRL_RST);
		wbXfer(1'b0, 4'hC, 32'h0, rd);
		check(rd, 32'h0);
		burst(2, 8'hE0);
		i_slsp_user_src.stop();
		waitLink;
		check(rxQ.size(), 0);
		wbXfer(1'b0, 4'h4, 32'h0, rd);
		check(rd[1:0], 2'h3);
		wbXfer(1'b0, 4'h8, 32'h0, rd);
		check(rd[4], 1'b1);
		// clear only the error bits; the link-up bit must survive
		wbXfer(1'b1, 4'h8, 32'h0F, rd);
		wbXfer(1'b0, 4'h8, 32'h0, rd);
		check(rd[4:0], 5'h10);
		wbXfer(1'b1, 4'h8, 32'h10, rd);
		$display("test reset and link done");
		burst(3, 8'hA0);
		i_slsp_user_src.stop();
		checkRx(3, 8'hA0);
		$display("test burst done");
		// gap 0: back to back is legal, three idle cycles is not
		burst(3, 8'hB0);
		gapErrs = 0;
		burst(2, 8'hB1);
		i_slsp_user_src.stop();
		repeat (3) @(posedge clk_sys);
		check(gapErrs, 0);
		burst(2, 8'hB2);
		i_slsp_user_src.stop();
		checkRx(3, 8'hB0);
		checkRx(2, 8'hB1);
		checkRx(2, 8'hB2);
		check(gapErrs, 1);
		wbXfer(1'b0, 4'h8, 32'h0, rd);
		check(rd[3:1], 3'h4);
		wbXfer(1'b1, 4'h8, 32'h1F, rd);
		$display("test burst gap done");
		wbXfer(1'b1, 4'hC, 32'h1, rd);
		laneReady <= 1'b0;
		burst(6, 8'hC0);
		i_slsp_user_src.stop();
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1);
		laneReady <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rxQ.delete();
		wbXfer(1'b1, 4'h8, 32'h1F, rd);
		check(irq, 1'b0);
		$display("test overflow done");
		coreReset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(linkUpTx, 1'b0);
		check(userClockResetTxOut, 1'b1);
		coreReset <= 1'b0;
		waitLink;
		check(userClockResetTxOut, 1'b0);
		$display("test core reset done");
		wbXfer(1'b1, 4'h0, 32'h3, rd);
		check(userClockTxOe, 1'b0);
		coreReset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(interfaceClockResetTx, 1'b1);
		coreReset <= 1'b0;
		waitLink;
		check(interfaceClockResetTx, 1'b0);
		userClockResetTxIn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check(linkUpTx, 1'b0);
		userClockResetTxIn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check(linkUpTx, 1'b1);
		$display("test advanced mode done");
		finalReport;
	end
endmodule // slsp_source_port_tb_top
bind slsp_source_port slsp_props i_slsp_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.coreReset(coreReset), .txPllLocked(txPllLocked), .userClockTxOut(userClockTxOut),
	.userClockTxOe(userClockTxOe), .userClockResetTxOut(userClockResetTxOut),
	.userClockResetTxOe(userClockResetTxOe), .interfaceClockResetTx(interfaceClockResetTx),
	.linkUpTx(linkUpTx), .validTx(validTx), .sourceBurstFirst(sourceBurstFirst),
	.errorTx(errorTx), .laneData(laneData), .laneValid(laneValid), .laneReady(laneReady),
	.wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck));
